// [verilog/ddio_pkg.sv]
// ddio_pkg: register map, field layouts, reset values and timing counts
// for the debounced sixteen-channel field i/o port.
// assumes a 20 MHz core clock and a plain strobe register port.
`default_nettype none

package ddio_pkg;

	// ----------------------------------------------------------------
	// geometry
	// ----------------------------------------------------------------
	localparam int unsigned CHANNELS  = 16;
	localparam int unsigned ADDR_W    = 4;
	localparam int unsigned DATA_W    = 32;

	// ----------------------------------------------------------------
	// register word offsets
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFS_CTRL      = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_DIR       = 4'h1;
	localparam logic [ADDR_W-1:0] OFS_OUT       = 4'h2;
	localparam logic [ADDR_W-1:0] OFS_IN        = 4'h3;
	localparam logic [ADDR_W-1:0] OFS_DB_EN     = 4'h4;
	localparam logic [ADDR_W-1:0] OFS_DB_SEL    = 4'h5;
	localparam logic [ADDR_W-1:0] OFS_SC_EN     = 4'h6;
	localparam logic [ADDR_W-1:0] OFS_LVL_EN    = 4'h7;
	localparam logic [ADDR_W-1:0] OFS_LVL_POL   = 4'h8;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STAT  = 4'h9;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK  = 4'ha;

	// ----------------------------------------------------------------
	// fields and reset values
	// ----------------------------------------------------------------
	localparam int unsigned CTRL_SOFT_RST_BIT = 0;
	localparam logic [15:0] RST_DIR      = 16'h0000;
	localparam logic [15:0] RST_OUT      = 16'h0000;
	localparam logic [15:0] RST_DB_EN    = 16'h0000;
	localparam logic [31:0] RST_DB_SEL   = 32'h0000_0000;
	localparam logic [15:0] RST_EN       = 16'h0000;
	localparam logic [15:0] RST_MASK     = 16'h0000;

	// debounce duration codes, two bits per channel
	localparam logic [1:0] DB_4US  = 2'h0;
	localparam logic [1:0] DB_64US = 2'h1;
	localparam logic [1:0] DB_1MS  = 2'h2;
	localparam logic [1:0] DB_8MS  = 2'h3;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ     = 20_000_000;
	localparam int unsigned T_DB0_NS   = 4_000;
	localparam int unsigned T_DB1_NS   = 64_000;
	localparam int unsigned T_DB2_NS   = 1_000_000;
	localparam int unsigned T_DB3_NS   = 8_000_000;
	// a 1 us tick keeps per-channel counters narrow
	localparam int unsigned T_TICK_NS  = 1_000;
	localparam int unsigned TICK_CYC   = T_TICK_NS / (1_000_000_000 / CLK_HZ);
	localparam int unsigned DB0_TICKS  = T_DB0_NS / T_TICK_NS;
	localparam int unsigned DB1_TICKS  = T_DB1_NS / T_TICK_NS;
	localparam int unsigned DB2_TICKS  = T_DB2_NS / T_TICK_NS;
	localparam int unsigned DB3_TICKS  = T_DB3_NS / T_TICK_NS;
	localparam int unsigned DBC_W      = 14;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} ddio_bus_req_t;

	typedef struct packed {
		logic [CHANNELS-1:0] o;
		logic [CHANNELS-1:0] oe;
	} ddio_pins_t;

endpackage : ddio_pkg

`default_nettype wire

// [verilog/ddio_port.sv]
// ddio_port: sixteen-channel field i/o with per-channel debounce,
// state change and level match interrupts.
// assumes field inputs are asynchronous; the core runs on one 20 MHz clock.
`default_nettype none

module ddio_port
(
	// clock and reset
	input  wire logic                            ref_clk_i,
	input  wire logic                            rst_n_i,
	// register port
	input  wire ddio_pkg::ddio_bus_req_t         bus_i,
	output logic [ddio_pkg::DATA_W-1:0]          rdata_o,
	// field pins
	input  wire logic [ddio_pkg::CHANNELS-1:0]   field_i,
	output ddio_pkg::ddio_pins_t                 field_o,
	// interrupt
	output logic                                 irq_o
);

	localparam int unsigned N = ddio_pkg::CHANNELS;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [ddio_pkg::DBC_W-1:0] db_limit
	(
		input logic [1:0] sel
	);
		case (sel)
			ddio_pkg::DB_4US:  db_limit = ddio_pkg::DBC_W'(ddio_pkg::DB0_TICKS);
			ddio_pkg::DB_64US: db_limit = ddio_pkg::DBC_W'(ddio_pkg::DB1_TICKS);
			ddio_pkg::DB_1MS:  db_limit = ddio_pkg::DBC_W'(ddio_pkg::DB2_TICKS);
			default:           db_limit = ddio_pkg::DBC_W'(ddio_pkg::DB3_TICKS);
		endcase
	endfunction : db_limit

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [N-1:0]   dir;
	logic [N-1:0]   out_val;
	logic [N-1:0]   db_en;
	logic [2*N-1:0] db_sel;
	logic [N-1:0]   state_change_en;
	logic [N-1:0]   lvl_en;
	logic [N-1:0]   lvl_pol;
	logic [N-1:0]   irq_stat;
	logic [N-1:0]   irq_mask;
	logic           soft_rst;

	// ----------------------------------------------------------------
	// write decode
	// ----------------------------------------------------------------
	function automatic logic wr_hit
	(
		input logic                        stb,
		input logic [ddio_pkg::ADDR_W-1:0] addr,
		input logic [ddio_pkg::ADDR_W-1:0] ofs
	);
		wr_hit = stb && addr == ofs;
	endfunction : wr_hit

	wire                        wr;
	wire                        rd;
	wire [ddio_pkg::ADDR_W-1:0] a;
	wire [N-1:0]                wlo;
	wire                        clr_all;
	wire                        ctrl_wr;
	wire                        next_soft_rst;
	wire                        wr_dir;
	wire                        wr_out;
	wire                        wr_db_en;
	wire                        wr_db_sel;
	wire                        wr_sc_en;
	wire                        wr_lvl_en;
	wire                        wr_lvl_pol;
	wire                        wr_mask;
	wire                        wr_stat;

	assign wr            = bus_i.wr;
	assign rd            = bus_i.rd;
	assign a             = bus_i.addr;
	assign wlo           = bus_i.wdata[N-1:0];
	// a soft reset clears the registers and status like the pin, one cycle late; debounce, tick and read data are left running
	assign clr_all       = !rst_n_i || soft_rst;
	assign ctrl_wr       = wr_hit(wr, a, ddio_pkg::OFS_CTRL);
	assign next_soft_rst = ctrl_wr && bus_i.wdata[ddio_pkg::CTRL_SOFT_RST_BIT];
	assign wr_dir        = wr_hit(wr, a, ddio_pkg::OFS_DIR);
	assign wr_out        = wr_hit(wr, a, ddio_pkg::OFS_OUT);
	assign wr_db_en      = wr_hit(wr, a, ddio_pkg::OFS_DB_EN);
	assign wr_db_sel     = wr_hit(wr, a, ddio_pkg::OFS_DB_SEL);
	assign wr_sc_en      = wr_hit(wr, a, ddio_pkg::OFS_SC_EN);
	assign wr_lvl_en     = wr_hit(wr, a, ddio_pkg::OFS_LVL_EN);
	assign wr_lvl_pol    = wr_hit(wr, a, ddio_pkg::OFS_LVL_POL);
	assign wr_mask       = wr_hit(wr, a, ddio_pkg::OFS_IRQ_MASK);
	assign wr_stat       = wr_hit(wr, a, ddio_pkg::OFS_IRQ_STAT);

	// soft reset is a one-cycle pulse from a control write
	always_ff @(posedge ref_clk_i)
		if (!rst_n_i)
			soft_rst <= 1'b0;
		else
			soft_rst <= next_soft_rst;

	// every channel falls back to input on either reset
	always_ff @(posedge ref_clk_i)
		if (clr_all)
			dir <= ddio_pkg::RST_DIR;
		else if (wr_dir)
			dir <= wlo;

	always_ff @(posedge ref_clk_i)
		if (clr_all)
			out_val <= ddio_pkg::RST_OUT;
		else if (wr_out)
			out_val <= wlo;

	always_ff @(posedge ref_clk_i)
		if (clr_all)
			db_en <= ddio_pkg::RST_DB_EN;
		else if (wr_db_en)
			db_en <= wlo;

	always_ff @(posedge ref_clk_i)
		if (clr_all)
			db_sel <= ddio_pkg::RST_DB_SEL;
		else if (wr_db_sel)
			db_sel <= bus_i.wdata;

	always_ff @(posedge ref_clk_i)
		if (clr_all)
			state_change_en <= ddio_pkg::RST_EN;
		else if (wr_sc_en)
			state_change_en <= wlo;

	always_ff @(posedge ref_clk_i)
		if (clr_all)
			lvl_en <= ddio_pkg::RST_EN;
		else if (wr_lvl_en)
			lvl_en <= wlo;

	always_ff @(posedge ref_clk_i)
		if (clr_all)
			lvl_pol <= ddio_pkg::RST_EN;
		else if (wr_lvl_pol)
			lvl_pol <= wlo;

	always_ff @(posedge ref_clk_i)
		if (clr_all)
			irq_mask <= ddio_pkg::RST_MASK;
		else if (wr_mask)
			irq_mask <= wlo;

	// ----------------------------------------------------------------
	// input synchroniser and microsecond tick
	// ----------------------------------------------------------------
	logic [N-1:0] sync_a;
	logic [N-1:0] sync_b;
	logic [$clog2(ddio_pkg::TICK_CYC)-1:0] tick_cnt;
	wire tick = tick_cnt == '0;

	// only sync_b feeds logic; sync_a may still be settling
	always_ff @(posedge ref_clk_i)
	begin
		sync_a <= field_i;
		sync_b <= sync_a;
	end

	// one shared tick keeps every channel counter at 14 bits
	// debounce time base is the 1 us tick, made every 20 system clock cycles
	always_ff @(posedge ref_clk_i)
		if (!rst_n_i || tick)
			tick_cnt <= ($clog2(ddio_pkg::TICK_CYC))'(ddio_pkg::TICK_CYC - 1);
		else
			tick_cnt <= tick_cnt - 1'b1;

	// ----------------------------------------------------------------
	// per-channel debounce
	// ----------------------------------------------------------------
	logic [N-1:0] clean;
	logic [N-1:0] clean_d;

	for (genvar i = 0; i < N; i++)
	begin : g_db
		logic [ddio_pkg::DBC_W-1:0] cnt;
		logic                       lvl;
		wire  [ddio_pkg::DBC_W-1:0] lim;
		wire                        differs;
		wire                        accept;

		assign lim      = db_limit(db_sel[2*i +: 2]);
		assign differs  = sync_b[i] != lvl;
		// counter must reach the limit and see one more tick, so a level exactly as long is dropped
		assign accept   = !db_en[i] || (tick && cnt >= lim);
		assign clean[i] = lvl;

		always_ff @(posedge ref_clk_i)
		begin
			if (!rst_n_i)
			begin
				cnt <= '0;
				lvl <= 1'b1;
			end
			else if (!differs)
				cnt <= '0; // short pulse restarts the count
			else if (accept)
			begin
				lvl <= sync_b[i];
				cnt <= '0;
			end
			else if (tick)
				cnt <= cnt + 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i)
		if (!rst_n_i)
			clean_d <= '1;
		else
			clean_d <= clean;

	// ----------------------------------------------------------------
	// interrupt events and status
	// ----------------------------------------------------------------
	wire [N-1:0] state_change_event;
	wire [N-1:0] ev_lvl;
	wire [N-1:0] st_clr;
	wire [N-1:0] events;
	wire [N-1:0] next_irq_stat;

	assign state_change_event = (clean ^ clean_d) & state_change_en;
	// a level match keeps setting status while it lasts
	assign ev_lvl = ~(clean ^ lvl_pol) & lvl_en;
	assign st_clr = wr_stat ? wlo : '0;
	assign events = state_change_event | ev_lvl;
	// set wins over a clear in the same cycle
	assign next_irq_stat = (irq_stat & ~st_clr) | events;

	always_ff @(posedge ref_clk_i)
		if (clr_all)
			irq_stat <= '0;
		else
			irq_stat <= next_irq_stat;

	assign irq_o = |(irq_stat & irq_mask);

	// ----------------------------------------------------------------
	// field drive
	// ----------------------------------------------------------------
	// no drive until software picks a direction per channel
	assign field_o.o  = out_val;
	assign field_o.oe = dir;

	// ----------------------------------------------------------------
	// read port
	// ----------------------------------------------------------------
	logic [ddio_pkg::DATA_W-1:0] rsel;

	always_comb
	begin
		case (a)
			ddio_pkg::OFS_DIR:      rsel = {16'h0000, dir};
			ddio_pkg::OFS_OUT:      rsel = {16'h0000, out_val};
			ddio_pkg::OFS_IN:       rsel = {16'h0000, clean};
			ddio_pkg::OFS_DB_EN:    rsel = {16'h0000, db_en};
			ddio_pkg::OFS_DB_SEL:   rsel = db_sel;
			ddio_pkg::OFS_SC_EN:    rsel = {16'h0000, state_change_en};
			ddio_pkg::OFS_LVL_EN:   rsel = {16'h0000, lvl_en};
			ddio_pkg::OFS_LVL_POL:  rsel = {16'h0000, lvl_pol};
			ddio_pkg::OFS_IRQ_STAT: rsel = {16'h0000, irq_stat};
			ddio_pkg::OFS_IRQ_MASK: rsel = {16'h0000, irq_mask};
			default:                rsel = 32'h0000_0000;
		endcase
	end

	// reads never touch status, so only a write or the reset pin clears it
	always_ff @(posedge ref_clk_i)
		if (!rst_n_i || !rd)
			rdata_o <= '0;
		else
			rdata_o <= rsel;

endmodule : ddio_port

`default_nettype wire

// [tb/ddio_port_sva.sv]
// ddio_port_sva: port checks of the field i/o port
// assumes a bind onto ddio_port from the bench top
`default_nettype none
module ddio_port_sva
(
	// watched ports
	input wire logic                    ref_clk_i,
	input wire logic                    rst_n_i,
	input wire ddio_pkg::ddio_bus_req_t bus_i,
	input wire logic [31:0]             rdata_o,
	input wire logic [15:0]             field_i,
	input wire ddio_pkg::ddio_pins_t    field_o,
	input wire logic                    irq_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	wire logic [3:0]  a   = bus_i.addr;
	wire logic [15:0] wd  = bus_i.wdata[15:0];
	wire logic        sft = bus_i.wr && a == 4'h0 && bus_i.wdata[0];
	wire logic        clr = bus_i.wr && (a == 4'h0 || a == 4'h9 || a == 4'ha);
	sequence s_no_rd;
		!bus_i.rd [*2];
	endsequence
	AST_RST_SAFE: assert property (
		$rose(rst_n_i) |-> field_o.oe == 16'h0000 && !irq_o)
		else $error("outputs live after reset");
	AST_SOFT_SAFE: assert property (
		sft |-> ##2 field_o.oe == 16'h0000 && field_o.o == 16'h0000 && !irq_o)
		else $error("soft reset left outputs live");
	AST_DIR_TAKE: assert property (
		bus_i.wr && a == 4'h1 |=> field_o.oe == $past(wd))
		else $error("direction write not taken");
	AST_IRQ_HOLD: assert property (
		irq_o && !clr && !$past(sft) |=> irq_o)
		else $error("interrupt dropped without clear");
	AST_MASK_GATE: assert property (
		bus_i.wr && a == 4'ha && wd == 16'h0000 |=> !irq_o)
		else $error("masked interrupt still raised");
	AST_RD_IDLE: assert property (
		s_no_rd |-> rdata_o == 32'h0000_0000)
		else $error("read data outside its cycle");
endmodule : ddio_port_sva
`default_nettype wire

// [tb/ddio_field_model.sv]
// ddio_field_model: field lines in front of the port, driven by the port or the sensors
// assumes the bench sets what the sensors apply
`default_nettype none
module ddio_field_model
(
	// sensor and port side
	input  wire logic [15:0]          sense_i,
	input  wire ddio_pkg::ddio_pins_t pins_i,
	output logic [15:0]               line_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// a driven channel shows the port's own level, sensors lose
	assign line_o = (pins_i.oe & pins_i.o) | (~pins_i.oe & sense_i);
endmodule : ddio_field_model
`default_nettype wire

// [tb/ddio_port_bench.sv]
// ddio_port_bench: self-checking bench of the field i/o port
// assumes the checker and field model files are compiled first
`default_nettype none
module ddio_port_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic                    ref_clk_i;
	logic                    rst_n_i;
	ddio_pkg::ddio_bus_req_t bus;
	logic [31:0]             rdata;
	logic [15:0]             sense;
	logic [15:0]             line;
	ddio_pkg::ddio_pins_t    pins;
	logic                    irq;
	logic [31:0]             seed = 32'hbc6d6186;
	logic [31:0]             v;
	logic [31:0]             e;
	int                      miscompares = 0;
	int                      tests_run = 0;
	int                      cyc = 0;
	int                      nt[3];
	ddio_port ddio_port_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
		.bus_i(bus), .rdata_o(rdata), .field_i(line), .field_o(pins),
		.irq_o(irq));
	ddio_field_model ddio_field_model_inst (.sense_i(sense),
		.pins_i(pins), .line_o(line));
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	function automatic logic [31:0] lvl(logic [15:0] i, logic [15:0] p);
		return {16'h0000, ~(i ^ p)};
	endfunction : lvl
	task automatic chk(input logic [31:0] got, input logic [31:0] ex);
		tests_run++;
		if (got !== ex)
		begin
			miscompares++;
			$display("Error %0t: got %h want %h", $time, got, ex);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge ref_clk_i);
		bus.wr <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [31:0] ex);
		@(posedge ref_clk_i);
		bus <= '{a, 32'h0000_0000, 1'b0, 1'b1};
		@(posedge ref_clk_i);
		bus.rd <= 1'b0;
		#1 chk(rdata, ex);
	endtask : rd
	task automatic hold(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask : hold
	task automatic end_sim();
		$display("tests_run %0d miscompares %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_sim
	initial
	begin
		ref_clk_i = 1'b0;
		forever #25 ref_clk_i = ~ref_clk_i;
	end
	// ceiling covers the 1 ms debounce runs with margin
	always @(posedge ref_clk_i)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			miscompares++;
			$display("Error %0t: run timed out", $time);
			end_sim();
		end
	end
	initial
	begin
		nt = '{ddio_pkg::DB0_TICKS, ddio_pkg::DB1_TICKS, ddio_pkg::DB2_TICKS};
		rst_n_i = 1'b0;
		bus = '0;
		sense = 16'hffff;
		hold(8);
		rst_n_i <= 1'b1;
		@(posedge ref_clk_i);
		#1 chk(32'(pins.oe), 32'h0);
		v = rnd();
		wr(4'h1, v);
		chk(32'(pins.oe), {16'h0, v[15:0]});
		wr(4'h2, v >> 16);
		chk(32'(pins.o & pins.oe), {16'h0, v[31:16] & v[15:0]});
		wr(4'h5, 32'he4e4_e4e4);
		rd(4'h5, 32'he4e4_e4e4);
		rd(4'hb, 32'h0);
		wr(4'h0, 32'h1);
		rd(4'h1, 32'h0);
		$display("test registers done");
		wr(4'ha, 32'hffff);
		e = rnd();
		wr(4'h6, e);
		v = rnd();
		@(posedge ref_clk_i) sense <= v[15:0];
		hold(6);
		rd(4'h9, {16'h0, e[15:0] & ~v[15:0]});
		chk(32'(irq), 32'(|(e[15:0] & ~v[15:0])));
		wr(4'h9, 32'hffff);
		chk(32'(irq), 32'h0);
		wr(4'h6, 32'h0);
		$display("test state change done");
		e = rnd();
		wr(4'h8, e);
		wr(4'h7, 32'hffff);
		rd(4'h9, lvl(v[15:0], e[15:0]));
		wr(4'h9, 32'hffff);
		rd(4'h9, lvl(v[15:0], e[15:0]));
		wr(4'ha, 32'h0);
		chk(32'(irq), 32'h0);
		wr(4'ha, 32'hffff);
		wr(4'h7, 32'h0);
		wr(4'h9, 32'hffff);
		rd(4'h9, 32'h0);
		$display("test level match done");
		// the 8 ms code is only read back: its run would blow the budget
		for (int k = 0; k < 3; k++)
		begin
			@(posedge ref_clk_i) sense <= 16'hffff;
			wr(4'h5, k);
			wr(4'h4, 32'h1);
			@(posedge ref_clk_i) sense <= 16'hfffe;
			hold((nt[k] - 2) * ddio_pkg::TICK_CYC);
			@(posedge ref_clk_i) sense <= 16'hffff;
			hold(3 * ddio_pkg::TICK_CYC);
			rd(4'h3, 32'hffff);
			@(posedge ref_clk_i) sense <= 16'hfffc;
			hold(5);
			rd(4'h3, 32'hfffd);
			hold((nt[k] + 2) * ddio_pkg::TICK_CYC);
			rd(4'h3, 32'hfffc);
			wr(4'h4, 32'h0);
		end
		$display("test debounce done");
		end_sim();
	end
endmodule : ddio_port_bench
bind ddio_port ddio_port_sva ddio_port_sva_inst (.ref_clk_i(ref_clk_i),
	.rst_n_i(rst_n_i), .bus_i(bus_i), .rdata_o(rdata_o),
	.field_i(field_i), .field_o(field_o), .irq_o(irq_o));
`default_nettype wire
